// ### rtl/arl_pkg.sv
/*
   arl_pkg: constants, register map and enumerations for the alarm relay logic.
   Assumes a single 10 MHz pclk domain and a 32-bit APB register bus.
*/
package arl_pkg;

   // timebase
   localparam int          ARL_CLK_NS        = 100;
   localparam longint      ARL_ONE_S_NS      = 64'd1000000000;
   localparam int          ARL_TICK_CYCLES   = int'(ARL_ONE_S_NS / ARL_CLK_NS);
   localparam int          ARL_TICK_W        = 24;
   localparam logic [1:0]  ARL_HOLD_TICKS    = 2'h2;   // two tick edges give at least one full second
   localparam logic [1:0]  ARL_CLEAR_LAST    = 2'h2;   // index of the third clear press

   // register byte offsets
   localparam logic [11:0] ARL_OFS_CTRL      = 12'h000;
   localparam logic [11:0] ARL_OFS_HYST      = 12'h004;
   localparam logic [11:0] ARL_OFS_LIMIT     = 12'h008;
   localparam logic [11:0] ARL_OFS_ERRTHR    = 12'h00C;
   localparam logic [11:0] ARL_OFS_STATUS    = 12'h010;

   // control field positions
   localparam int          ARL_CTRL_FUNC_LSB = 0;
   localparam int          ARL_CTRL_HOLD     = 3;
   localparam int          ARL_CTRL_NC       = 4;
   localparam int          ARL_CTRL_EN       = 5;
   localparam int          ARL_CTRL_SHOW     = 6;

   // status field positions
   localparam int          ARL_STAT_HOLD     = 3;
   localparam int          ARL_STAT_NC       = 4;
   localparam int          ARL_STAT_CLOSED   = 5;
   localparam int          ARL_STAT_ACTIVE   = 6;
   localparam int          ARL_STAT_STOPPED  = 7;

   // reset / initialization values
   localparam logic [31:0] ARL_RST_HYST      = 32'h0000_0000;
   localparam logic [31:0] ARL_RST_LIMIT     = 32'h0000_0000;
   localparam logic [7:0]  ARL_RST_ERRTHR    = 8'h05;

   // switching condition, in indication order
   typedef enum logic [2:0] {
      ARL_FUNC_OFF, ARL_FUNC_MAX, ARL_FUNC_MIN, ARL_FUNC_DIR, ARL_FUNC_QUANT, ARL_FUNC_ERROR
   } arl_func_e;

   // alarm output state
   typedef enum logic [1:0] {
      ARL_ST_IDLE, ARL_ST_ACTIVE, ARL_ST_REARM, ARL_ST_STOPPED
   } arl_state_e;

endpackage

// ### rtl/arl_alarm_relay.sv
/*
   arl_alarm_relay: one alarm relay output with limit comparison, hysteresis,
   holding behaviour, contact function, operator actions and APB registers.
   Assumes measurement, totalizer, flow direction and keypad events arrive from
   logic on pclk, one-cycle strobes unless noted as levels.
*/
// Overview of operation
// - hysteresis band sits symmetric about limit, plus and minus half the hysteresis
// - max activates above upper threshold, deactivates only below lower threshold; min the reverse
// - zero hysteresis switches right at the limit; band only for max and min
// - compare against full precision values, never rounded display values
// - initialization restores off, non-latching, normally open, limit zero
// - three clear presses idle the output; still-met condition reactivates after 1 s
// - break key de-energizes output regardless of programmed idle state
// - start of transducer positioning returns output to idle
// - bar graph selected during measurement returns output to idle
// - latched alarm stays idle after positioning if condition no longer met
// - max and min outputs re-evaluated at most once per second
// - non-latching output follows condition, held active at least 1 s
// - totalizer-limit output activates when totalizer reaches the limit
// - error output activates only after several consecutive failed attempts
// - non-latching direction-change output pulses about 1 s per reversal
// - latching direction-change output stays active until three clear presses
// - measurement re-adaptation never switches any alarm output
// - condition off forces contact function to normally open
// - state indication reports condition, holding, contact function, contact state
// - disabling output keeps its stored configuration
// - max condition switches when measured value exceeds the upper limit
// - min condition switches when measured value drops below the lower limit
// - positive limit checks positive totalizer, negative limit checks negative totalizer
`timescale 1ns/1ns
module arl_alarm_relay #(
   parameter int TICK_CYCLES = arl_pkg::ARL_TICK_CYCLES,
   parameter int ERR_W       = 8
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] meas_value,
   input  wire logic        meas_valid,
   input  wire logic        meas_fail,
   input  wire logic [31:0] tot_pos,
   input  wire logic [31:0] tot_neg,
   input  wire logic        flow_dir,
   input  wire logic        measuring,
   input  wire logic        readapt,
   input  wire logic        clear_key,
   input  wire logic        break_key,
   input  wire logic        positioning_start,
   input  wire logic        bargraph_select,
   input  wire logic        init_req,
   output logic             relay_coil,
   output logic             contact_closed
);

   logic [arl_pkg::ARL_TICK_W-1:0] tick_cnt_q;
   logic                           tick;
   logic [2:0]                     func_q;
   logic                           hold_q;
   logic                           nc_q;
   logic                           en_q;
   logic                           show_q;
   logic [31:0]                    hyst_q;
   logic [31:0]                    limit_q;
   logic [ERR_W-1:0]               errthr_q;
   logic [31:0]                    val_q;
   logic [ERR_W-1:0]               fail_cnt_q;
   logic                           cond_mm_q;
   logic                           dir_q;
   logic                           run_q;
   logic [1:0]                     clr_cnt_q;
   logic [1:0]                     tmr_q;
   arl_pkg::arl_state_e            st_q;
   arl_pkg::arl_state_e            st_d;
   logic [1:0]                     tmr_d;

   // one-second tick shared by every timer
   assign tick = clk_en && (tick_cnt_q == arl_pkg::ARL_TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
      end else if (clk_en) begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      end
   end

   // apb decode; no wait states, frozen while clock enable is low
   wire        acc      = psel && penable && clk_en;
   wire        wr       = acc && pwrite;
   wire        sel_ctrl = (paddr == arl_pkg::ARL_OFS_CTRL);
   wire        sel_hyst = (paddr == arl_pkg::ARL_OFS_HYST);
   wire        sel_lim  = (paddr == arl_pkg::ARL_OFS_LIMIT);
   wire        sel_err  = (paddr == arl_pkg::ARL_OFS_ERRTHR);
   wire        sel_stat = (paddr == arl_pkg::ARL_OFS_STATUS);
   wire        mapped   = sel_ctrl | sel_hyst | sel_lim | sel_err | sel_stat;
   wire [2:0]  wr_func  = pwdata[arl_pkg::ARL_CTRL_FUNC_LSB +: 3];
   wire        func_off = (func_q == arl_pkg::ARL_FUNC_OFF);
   wire        nc_eff   = nc_q && !func_off;
   assign pready  = clk_en;
   assign pslverr = psel && penable && !mapped;

   // configuration registers; disabling keeps the rest of the setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_q   <= arl_pkg::ARL_FUNC_OFF;
         hold_q   <= 1'b0;
         nc_q     <= 1'b0;
         en_q     <= 1'b0;
         show_q   <= 1'b0;
         hyst_q   <= arl_pkg::ARL_RST_HYST;
         limit_q  <= arl_pkg::ARL_RST_LIMIT;
         errthr_q <= ERR_W'(arl_pkg::ARL_RST_ERRTHR);
      end else if (clk_en && init_req) begin
         func_q   <= arl_pkg::ARL_FUNC_OFF;
         hold_q   <= 1'b0;
         nc_q     <= 1'b0;
         limit_q  <= arl_pkg::ARL_RST_LIMIT;
      end else if (wr && sel_ctrl) begin
         func_q   <= wr_func;
         hold_q   <= pwdata[arl_pkg::ARL_CTRL_HOLD];
         nc_q     <= pwdata[arl_pkg::ARL_CTRL_NC] && (wr_func != arl_pkg::ARL_FUNC_OFF);
         en_q     <= pwdata[arl_pkg::ARL_CTRL_EN];
         show_q   <= pwdata[arl_pkg::ARL_CTRL_SHOW];
      end else if (wr && sel_hyst) begin
         hyst_q   <= pwdata;
      end else if (wr && sel_lim) begin
         limit_q  <= pwdata;
      end else if (wr && sel_err) begin
         errthr_q <= pwdata[ERR_W-1:0];
      end
   end

   // thresholds in 33 bits so the band never wraps around
   wire signed [32:0] lim_s  = {limit_q[31], limit_q};
   wire signed [32:0] half_s = $signed({hyst_q[31], hyst_q}) >>> 1;      // signed so a negative band keeps its sign
   wire signed [32:0] thr_hi = lim_s + half_s;
   wire signed [32:0] thr_lo = lim_s - half_s;
   wire signed [32:0] val_s  = {val_q[31], val_q};
   wire               above  = val_s > thr_hi;
   wire               below  = val_s < thr_lo;
   wire               is_max = (func_q == arl_pkg::ARL_FUNC_MAX);
   wire               is_min = (func_q == arl_pkg::ARL_FUNC_MIN);
   wire               pos_evt = positioning_start || (bargraph_select && measuring);

   // latest raw sample; the display rounding never reaches this path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         val_q <= 32'h0000_0000;
      end else if (clk_en && meas_valid) begin
         val_q <= meas_value;
      end
   end

   // max/min condition with hysteresis memory, paced by the tick against humming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_mm_q <= 1'b0;
      end else if (clk_en && (pos_evt || init_req)) begin
         cond_mm_q <= 1'b0;
      end else if (tick && is_max) begin
         cond_mm_q <= above ? 1'b1 : (below ? 1'b0 : cond_mm_q);
      end else if (tick && is_min) begin
         cond_mm_q <= below ? 1'b1 : (above ? 1'b0 : cond_mm_q);
      end
   end

   // consecutive failed attempts; a good result restarts the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_cnt_q <= '0;
      end else if (clk_en && meas_valid) begin
         fail_cnt_q <= '0;
      end else if (clk_en && meas_fail && (fail_cnt_q != '1)) begin
         fail_cnt_q <= fail_cnt_q + 1'b1;
      end
   end

   // totalizer compare picks its totalizer by the sign of the limit
   wire quant_met = limit_q[31] ? ($signed(tot_neg) <= $signed(limit_q))
                                : ($signed(tot_pos) >= $signed(limit_q));
   wire err_met   = (fail_cnt_q >= errthr_q) && (errthr_q != '0);
   wire dir_evt   = run_q && (flow_dir != dir_q);

   // selected switching condition
   wire cond = ((is_max || is_min) && cond_mm_q)
            || ((func_q == arl_pkg::ARL_FUNC_QUANT) && quant_met)
            || ((func_q == arl_pkg::ARL_FUNC_ERROR) && err_met);
   wire is_dir   = (func_q == arl_pkg::ARL_FUNC_DIR);
   wire want_set = en_q && !func_off && (is_dir ? dir_evt : cond);

   // operator edges: run start, direction history, clear-press count
   wire clear3 = clear_key && measuring && (clr_cnt_q == arl_pkg::ARL_CLEAR_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q     <= 1'b0;
         run_q     <= 1'b0;
         clr_cnt_q <= 2'h0;
      end else if (clk_en) begin
         dir_q     <= flow_dir;
         run_q     <= measuring;
         if (!measuring || clear3) begin
            clr_cnt_q <= 2'h0;
         end else if (clear_key) begin
            clr_cnt_q <= clr_cnt_q + 2'h1;
         end
      end
   end

   // alarm state; break beats init beats positioning beats clear
   always_comb begin
      st_d  = st_q;
      tmr_d = (tick && (tmr_q != 2'h0)) ? tmr_q - 2'h1 : tmr_q;
      if (break_key) begin
         st_d  = arl_pkg::ARL_ST_STOPPED;
         tmr_d = 2'h0;
      end else if (init_req) begin
         st_d  = arl_pkg::ARL_ST_IDLE;
         tmr_d = 2'h0;
      end else if (pos_evt) begin
         st_d  = arl_pkg::ARL_ST_IDLE;
         tmr_d = 2'h0;
      end else if (clear3 && (st_q != arl_pkg::ARL_ST_STOPPED)) begin
         st_d  = arl_pkg::ARL_ST_REARM;
         tmr_d = arl_pkg::ARL_HOLD_TICKS;
      end else if (!readapt) begin
         case (st_q)
            arl_pkg::ARL_ST_IDLE: begin
               if (want_set) begin
                  st_d  = arl_pkg::ARL_ST_ACTIVE;
                  tmr_d = arl_pkg::ARL_HOLD_TICKS;
               end
            end
            arl_pkg::ARL_ST_ACTIVE: begin
               if (!en_q || func_off) begin
                  st_d = arl_pkg::ARL_ST_IDLE;
               end else if (is_dir && !hold_q && dir_evt) begin
                  tmr_d = arl_pkg::ARL_HOLD_TICKS;
               end else if (!hold_q && !(cond && !is_dir) && (tmr_q == 2'h0)) begin
                  st_d = arl_pkg::ARL_ST_IDLE;
               end
            end
            arl_pkg::ARL_ST_REARM: begin
               if (tmr_q == 2'h0) begin
                  st_d = arl_pkg::ARL_ST_IDLE;
               end
            end
            arl_pkg::ARL_ST_STOPPED: begin
               if (measuring && !run_q) begin
                  st_d = arl_pkg::ARL_ST_IDLE;
               end
            end
            default: begin
               st_d = arl_pkg::ARL_ST_IDLE;
            end
         endcase
      end
   end

   // state and relay drive registers
   wire active_d = (st_d == arl_pkg::ARL_ST_ACTIVE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q           <= arl_pkg::ARL_ST_IDLE;
         tmr_q          <= 2'h0;
         relay_coil     <= 1'b0;
         contact_closed <= 1'b0;
      end else if (clk_en) begin
         st_q           <= st_d;
         tmr_q          <= tmr_d;
         relay_coil     <= active_d;
         contact_closed <= active_d ^ nc_eff;
      end
   end

   // readback; status shows only with the indication option on
   wire [31:0] ctrl_rd = {25'h0, show_q, en_q, nc_q, hold_q, func_q};
   wire [31:0] stat_rd = show_q ? {24'h0, (st_q == arl_pkg::ARL_ST_STOPPED), relay_coil,
                                   contact_closed, nc_eff, hold_q, func_q} : 32'h0000_0000;
   wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd :
                         sel_hyst ? hyst_q  :
                         sel_lim  ? limit_q :
                         sel_err  ? {{(32-ERR_W){1'b0}}, errthr_q} :
                         sel_stat ? stat_rd : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite && clk_en) begin
         prdata <= rd_mux;
      end
   end

   // checks on the alarm behaviour
   wire quiet = clk_en && !break_key && !init_req && !pos_evt && !clear3;

   AST_MAX_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && is_max && above && !pos_evt && !init_req) |=> cond_mm_q)
      else $error("max condition not set above upper threshold");
   AST_BAND_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && is_max && cond_mm_q && !below && !pos_evt && !init_req && !wr) |=> cond_mm_q)
      else $error("max condition dropped inside the band");
   AST_PACE: assert property (@(posedge pclk) disable iff (!presetn)
      (!tick && !(clk_en && (pos_evt || init_req))) |=> $stable(cond_mm_q))
      else $error("max/min condition changed between ticks");
   AST_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && break_key) |=> (st_q == arl_pkg::ARL_ST_STOPPED) && !relay_coil)
      else $error("break key did not de-energize the output");
   AST_OFF_NO: assert property (@(posedge pclk) disable iff (!presetn)
      func_off |-> !nc_q)
      else $error("normally closed kept with condition off");
   AST_MIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (quiet && !readapt && en_q && !func_off && (st_q == arl_pkg::ARL_ST_ACTIVE) && (tmr_q != 2'h0))
      |=> (st_q == arl_pkg::ARL_ST_ACTIVE))
      else $error("active output released before its minimum hold");
   AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && clear3 && !break_key && !init_req && !pos_evt && (st_q != arl_pkg::ARL_ST_STOPPED))
      |=> (st_q == arl_pkg::ARL_ST_REARM) && (tmr_q == arl_pkg::ARL_HOLD_TICKS))
      else $error("third clear press did not idle the output");
   AST_POS: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && pos_evt && !break_key) |=> (st_q == arl_pkg::ARL_ST_IDLE) && !cond_mm_q)
      else $error("positioning did not return the output to idle");
   AST_BARGRAPH: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && bargraph_select && measuring && !break_key) |=> (st_q == arl_pkg::ARL_ST_IDLE) && !relay_coil)
      else $error("bar graph selection did not return the output to idle");
   AST_QUANT: assert property (@(posedge pclk) disable iff (!presetn)
      (quiet && !readapt && en_q && (func_q == arl_pkg::ARL_FUNC_QUANT) && quant_met
       && (st_q == arl_pkg::ARL_ST_IDLE)) |=> (st_q == arl_pkg::ARL_ST_ACTIVE) && relay_coil)
      else $error("totalizer limit reached without activating the output");
   AST_READAPT: assert property (@(posedge pclk) disable iff (!presetn)
      (quiet && readapt) |=> $stable(st_q))
      else $error("alarm switched during re-adaptation");
   AST_INIT: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && init_req) |=> func_off && !hold_q && !nc_q && (limit_q == 32'h0000_0000))
      else $error("initialization did not restore defaults");

endmodule // arl_alarm_relay

// ### verification/arl_far_side.sv
/*
   arl_far_side: keypad and relay contact circuit beside one alarm output.
   Assumes the bench raises a key command for one pclk cycle at a time.
*/
`timescale 1ns/1ns
module arl_far_side (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clr_cmd,
   input  wire logic brk_cmd,
   input  wire logic relay_coil,
   input  wire logic nc_wired,
   output logic      clear_key,
   output logic      break_key,
   output logic      contact_sense
);
   // keys pass through one register each, no debouncing, one cycle late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_key <= 1'b0;
         break_key <= 1'b0;
      end else begin
         clear_key <= clr_cmd;
         break_key <= brk_cmd;
      end
   end

   // a break contact closes while the coil is off
   assign contact_sense = relay_coil ^ nc_wired;
endmodule // arl_far_side

// ### verification/arl_alarm_relay_bench.sv
/*
   arl_alarm_relay_bench: register and alarm scenarios through APB and keys.
   Assumes a shortened one-second tick of 20 cycles and zero wait states.
*/
`timescale 1ns/1ns
module arl_alarm_relay_bench;
   localparam int TK = 20;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, sv_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, meas_value, tot_pos, tot_neg;
   logic        meas_valid, meas_fail, flow_dir, measuring, readapt, clear_key, break_key;
   logic        positioning_start, bargraph_select, init_req, relay_coil, contact_closed;
   logic        clr_cmd, brk_cmd, ok, nc_w, contact_sense;
   int          miscompares, check_count;

   arl_alarm_relay #(.TICK_CYCLES(TK)) u_arl_alarm_relay (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas_value(meas_value), .meas_valid(meas_valid),
      .meas_fail(meas_fail), .tot_pos(tot_pos), .tot_neg(tot_neg), .flow_dir(flow_dir),
      .measuring(measuring), .readapt(readapt), .clear_key(clear_key), .break_key(break_key),
      .positioning_start(positioning_start), .bargraph_select(bargraph_select), .init_req(init_req),
      .relay_coil(relay_coil), .contact_closed(contact_closed));
   arl_far_side u_arl_far_side (.pclk(pclk), .presetn(presetn), .clr_cmd(clr_cmd), .brk_cmd(brk_cmd),
      .relay_coil(relay_coil), .nc_wired(nc_w), .clear_key(clear_key), .break_key(break_key),
      .contact_sense(contact_sense));

   task automatic results();
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; sv_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] f, input logic h, input logic n, input logic e);
      return {25'h0, 1'b1, e, n, h, f};
   endfunction

   // one-cycle event: 0 clear, 1 break, 2 init, 3 failed attempt, 4 positioning, 5 bar graph
   task automatic key(input int k);
      @(posedge pclk);
      case (k)
         0: clr_cmd <= 1'b1;
         1: brk_cmd <= 1'b1;
         2: init_req <= 1'b1;
         3: meas_fail <= 1'b1;
         4: positioning_start <= 1'b1;
         default: bargraph_select <= 1'b1;
      endcase
      @(posedge pclk);
      {clr_cmd, brk_cmd, init_req, meas_fail, positioning_start, bargraph_select} <= 6'h00;
   endtask

   // bounded wait for the coil level, then compare
   task automatic wcoil(input logic v, input int lim, input string nm);
      int n;
      n = 0;
      while (relay_coil !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk(nm, {31'h0, v}, {31'h0, relay_coil});
   endtask

   task automatic hcoil(input logic v, input int cyc, input string nm);
      ok = 1'b1;
      repeat (cyc) begin
         @(posedge pclk);
         if (relay_coil !== v) ok = 1'b0;
      end
      chk(nm, 32'h1, {31'h0, ok});
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // watchdog: the scenarios take about 800 cycles
   initial begin
      repeat (8000) @(posedge pclk);
      miscompares++;
      results();
   end

   initial begin
      miscompares = 0; check_count = 0;
      presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; meas_value = 32'h0; meas_valid = 1'b1; meas_fail = 1'b0; tot_pos = 32'h0;
      tot_neg = 32'h0; flow_dir = 1'b0; measuring = 1'b1; readapt = 1'b0; positioning_start = 1'b0;
      bargraph_select = 1'b0; init_req = 1'b0; clr_cmd = 1'b0; brk_cmd = 1'b0; nc_w = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // register reset values and an unmapped place
      rdchk("ctrl", arl_pkg::ARL_OFS_CTRL, 32'h0);
      rdchk("limit", arl_pkg::ARL_OFS_LIMIT, 32'h0);
      rdchk("errthr", arl_pkg::ARL_OFS_ERRTHR, 32'h5);
      rdchk("status", arl_pkg::ARL_OFS_STATUS, 32'h0);
      rdchk("unmapped", 12'h014, 32'h0);
      chk("pslverr", 32'h1, {31'h0, sv_err});
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_OFF, 1'b0, 1'b1, 1'b1));
      rdchk("off_forces_no", arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_OFF, 1'b0, 1'b0, 1'b1));
      // max with a band of 2 about 30: upper 31, lower 29
      apb(1'b1, arl_pkg::ARL_OFS_LIMIT, 32'd30);
      apb(1'b1, arl_pkg::ARL_OFS_HYST, 32'd2);
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_MAX, 1'b0, 1'b0, 1'b1));
      meas_value <= 32'd31;
      hcoil(1'b0, 3 * TK, "upper_equal");
      meas_value <= 32'd32;
      wcoil(1'b1, TK + 5, "max_set");
      rdchk("status_act", arl_pkg::ARL_OFS_STATUS, 32'h61);
      meas_value <= 32'd30;
      hcoil(1'b1, 3 * TK, "in_band");
      meas_value <= 32'd28;
      wcoil(1'b0, 4 * TK, "max_clr");
      // re-adaptation must not switch
      readapt <= 1'b1; meas_value <= 32'd32;
      hcoil(1'b0, 3 * TK, "readapt");
      readapt <= 1'b0;
      wcoil(1'b1, TK + 5, "after_readapt");
      // latched max, released by three clears
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_MAX, 1'b1, 1'b0, 1'b1));
      meas_value <= 32'd28;
      hcoil(1'b1, 4 * TK, "latched");
      repeat (3) key(0);
      wcoil(1'b0, 4, "clear3");
      hcoil(1'b0, 4 * TK, "stay_idle");
      meas_value <= 32'd32;
      wcoil(1'b1, 2 * TK, "relatch");
      repeat (3) key(0);
      wcoil(1'b0, 4, "clear3_met");
      wcoil(1'b1, 4 * TK, "reactivate");
      // break stops the measurement
      key(1);
      wcoil(1'b0, 3, "break");
      rdchk("stopped", arl_pkg::ARL_OFS_STATUS, 32'h89);
      measuring <= 1'b0;
      @(posedge pclk);
      measuring <= 1'b1;
      // min at zero with no band, then positioning
      apb(1'b1, arl_pkg::ARL_OFS_HYST, 32'h0);
      apb(1'b1, arl_pkg::ARL_OFS_LIMIT, 32'h0);
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_MIN, 1'b0, 1'b1, 1'b1));
      // restart re-armed the met max condition; let it drop before the min set
      meas_value <= 32'd5; nc_w <= 1'b1;
      wcoil(1'b0, 4 * TK, "min_idle");
      meas_value <= 32'hFFFF_FFFF;
      wcoil(1'b1, 2 * TK, "min_set");
      chk("nc_contact", 32'h0, {31'h0, contact_closed});
      chk("contact_wiring", {31'h0, contact_sense}, {31'h0, contact_closed});
      // min no longer met, so positioning leaves it idle for the totalizer part
      meas_value <= 32'd200;
      key(4);
      wcoil(1'b0, 3, "positioning");
      // totalizer limits in both directions
      apb(1'b1, arl_pkg::ARL_OFS_LIMIT, 32'd100);
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_QUANT, 1'b0, 1'b0, 1'b1));
      tot_pos <= 32'd99;
      hcoil(1'b0, 3 * TK, "quant_below");
      tot_pos <= 32'd100;
      wcoil(1'b1, 3, "quant_reach");
      apb(1'b1, arl_pkg::ARL_OFS_LIMIT, 32'hFFFF_FFCE);
      tot_pos <= 32'd500; tot_neg <= 32'hFFFF_FFCF;
      wcoil(1'b0, 4 * TK, "neg_below");
      tot_neg <= 32'hFFFF_FFCE;
      wcoil(1'b1, 3, "neg_reach");
      // direction change pulse, at least one second long
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_DIR, 1'b0, 1'b0, 1'b1));
      wcoil(1'b0, 4 * TK, "dir_idle");
      flow_dir <= 1'b1;
      wcoil(1'b1, 3, "dir_pulse");
      hcoil(1'b1, TK - 1, "dir_min");
      wcoil(1'b0, 2 * TK, "dir_end");
      flow_dir <= 1'b0;
      wcoil(1'b1, 3, "dir_again");
      key(5);
      wcoil(1'b0, 3, "bargraph");
      // measurement error after three failed attempts
      meas_valid <= 1'b0;
      apb(1'b1, arl_pkg::ARL_OFS_ERRTHR, 32'h3);
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_ERROR, 1'b0, 1'b0, 1'b1));
      repeat (2) key(3);
      hcoil(1'b0, 5, "err_two");
      key(3);
      wcoil(1'b1, 3, "err_three");
      // disabled output keeps its configuration
      apb(1'b1, arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_MAX, 1'b1, 1'b1, 1'b0));
      rdchk("disabled_cfg", arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_MAX, 1'b1, 1'b1, 1'b0));
      rdchk("disabled_limit", arl_pkg::ARL_OFS_LIMIT, 32'hFFFF_FFCE);
      // initialization defaults
      key(2);
      rdchk("init_ctrl", arl_pkg::ARL_OFS_CTRL, ctl(arl_pkg::ARL_FUNC_OFF, 1'b0, 1'b0, 1'b0));
      rdchk("init_limit", arl_pkg::ARL_OFS_LIMIT, 32'h0);
      results();
   end
endmodule // arl_alarm_relay_bench
